// ---- design/sfbfe_pkg.sv ----
package sfbfe_pkg;

	// clock and timing
	localparam int CLK_MHZ         = 100;
	localparam int SW_RESET_NS     = 10000;
	localparam int HW_RESET_MIN_NS = 1000;
	// least times, rounded up to whole cycles
	localparam int SW_RESET_CYCLES =
		(SW_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int HW_RESET_CYCLES =
		(HW_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W           = 16;

	// opcodes
	localparam logic [7:0] OP_READ_DUAL_OUT  = 8'h3b;
	localparam logic [7:0] OP_READ_DUAL_IO   = 8'hbb;
	localparam logic [7:0] OP_READ_QUAD_OUT  = 8'h6b;
	localparam logic [7:0] OP_READ_QUAD_IO   = 8'heb;
	localparam logic [7:0] OP_ENTER_FOUR     = 8'h38;
	localparam logic [7:0] OP_EXIT_FOUR      = 8'hff;
	localparam logic [7:0] OP_RESET_ENABLE   = 8'h66;
	localparam logic [7:0] OP_RESET          = 8'h99;

	// lane widths and phase lengths
	localparam logic [2:0] LANE1      = 3'h1;
	localparam logic [2:0] LANE2      = 3'h2;
	localparam logic [2:0] LANE4      = 3'h4;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [2:0] ADDR_BYTES = 3'h3;
	localparam logic [2:0] ADDR_MODE  = 3'h4;
	localparam logic [3:0] DUMMY_LONG = 4'h8;
	localparam logic [3:0] DUMMY_QIO  = 4'h4;
	localparam logic [3:0] DUMMY_NONE = 4'h0;

	// pin values
	localparam logic [3:0] OE_FLOAT   = 4'hf;
	localparam logic [3:0] OE_SINGLE  = 4'hd;
	localparam logic [3:0] OE_DUAL    = 4'hc;
	localparam logic [3:0] OE_QUAD    = 4'h0;
	localparam logic [3:0] IO_IDLE    = 4'h0;
	localparam logic [7:0] FILL_BYTE  = 8'hff;

	// transmit buffer
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		ST_OPCODE   = 3'b000,
		ST_ADDR     = 3'b001,
		ST_DUMMY    = 3'b010,
		ST_DATA_IN  = 3'b011,
		ST_DATA_OUT = 3'b100,
		ST_IGNORE   = 3'b101
	} sfbfe_state_type;

endpackage

// ---- design/sfbfe_top.sv ----
// What this block does
// - modes 0 and 3: capture on rising clock, update outputs on falling.
// - a clock cycle spans falling edge to falling edge; first from select.
// - dual read opcodes use lines 0 and 1 as two-way data in serial mode, all four lines in four-wire mode.
// - quad read opcodes use four lines, write-protect and pause pins too.
// - quad read opcodes accepted only with quad enable set.
// - enter and exit opcodes switch to and from four-wire mode.
// - four-wire mode opcode in two clocks, serial mode in eight.
// - power-up and software reset leave serial mode active.
// - four-wire mode entry needs quad enable set.
// - pause works only with select low, never in quad operation.
// - pause starts on pin fall if clock low, else after clock fall.
// - pause ends on pin rise if clock low, else after clock fall.
// - while paused outputs float, inputs and clock ignored, state kept.
// - reset-enable then reset opcode back to back resets to power-on.
// - software reset takes 10 us and rejects commands meanwhile.
// - pin select 0 gives pause, 1 gives active-low hardware reset.
// - reset pin low for 1 us resets, aborts, blocks commands while low.
// - with quad enable set the shared pin is only data line 3.
// - dedicated reset pin works whatever select and quad enable are.
// - hardware reset overrides every other input and operation.
`timescale 1ns/1ps

module sfbfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// fill side
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	// drain side
	output logic      [WIDTH-1:0] o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	wire              push = i_in_valid & o_in_ready;
	wire              pop  = o_out_valid & i_out_ready;

	assign next_count = (push & ~pop) ? count + 1'b1 :
		(~push & pop) ? count - 1'b1 : count;
	assign o_out_data = mem[rd_ptr];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			count       <= '0;
			o_in_ready  <= 1'b1;
			o_out_valid <= 1'b0;
		end else begin
			wr_ptr      <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr      <= pop ? rd_ptr + 1'b1 : rd_ptr;
			count       <= next_count;
			o_in_ready  <= next_count != CW'(DEPTH);
			o_out_valid <= next_count != '0;
		end
	end
endmodule // sfbfe_fifo

module sfbfe_top (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// serial bus pins
	input  wire logic       i_cs_n,
	input  wire logic       i_sclk,
	input  wire logic [3:0] i_io,
	output logic      [3:0] o_io_out,
	output logic      [3:0] o_io_oe_n,
	input  wire logic       i_rst_pin_n,
	// configuration
	input  wire logic       i_quad_enable_bit,
	input  wire logic       i_pause_or_reset_pin_select,
	// received command stream
	output logic      [7:0] o_opcode,
	output logic            o_cmd_valid,
	output logic      [7:0] o_rx_byte,
	output logic            o_rx_valid,
	// read data to send
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_tx_ready,
	// status
	output logic            o_four_wire_instruction_mode,
	output logic            o_paused,
	output logic            o_sw_reset_busy,
	output logic            o_abort
);
	sfbfe_pkg::sfbfe_state_type state;

	logic                        sclk_q;
	logic [2:0]                  lane_w;
	logic [2:0]                  out_w;
	logic [3:0]                  bits;
	logic [7:0]                  sh;
	logic [2:0]                  left;
	logic [3:0]                  dummy;
	logic [7:0]                  txsh;
	logic [3:0]                  txleft;
	logic                        armed;
	logic [sfbfe_pkg::CNT_W-1:0] busy_cnt;
	logic [sfbfe_pkg::CNT_W-1:0] rst_cnt;
	logic [7:0]                  fifo_data;
	logic                        fifo_valid;

	wire four_wire_instruction_mode  = o_four_wire_instruction_mode;
	wire busy = o_sw_reset_busy;
	wire qe   = i_quad_enable_bit;

	// hardware reset: dedicated pin always, shared pin only if selected
	wire shared_rst = i_pause_or_reset_pin_select & ~qe & ~i_io[3];
	wire rst_low    = ~i_rst_pin_n | shared_rst;
	wire dev_reset  = rst_low &
		(rst_cnt == sfbfe_pkg::CNT_W'(sfbfe_pkg::HW_RESET_CYCLES - 1));

	// pause allowed only in single or dual serial work
	wire hold_ok = ~i_cs_n & ~qe & ~i_pause_or_reset_pin_select & ~four_wire_instruction_mode &
		(lane_w != sfbfe_pkg::LANE4) & (out_w != sfbfe_pkg::LANE4 |
		state != sfbfe_pkg::ST_DATA_OUT);

	wire active = ~i_cs_n & ~rst_low & ~o_paused;
	wire rise   = active & i_sclk & ~sclk_q;
	wire fall   = active & ~i_sclk & sclk_q;
	wire float_out = i_cs_n | rst_low | o_paused |
		(state != sfbfe_pkg::ST_DATA_OUT);

	// input shifting, one, two or four lanes per rising edge
	wire [7:0] rx_shift = (lane_w == sfbfe_pkg::LANE4) ? {sh[3:0], i_io} :
		(lane_w == sfbfe_pkg::LANE2) ? {sh[5:0], i_io[1:0]} :
		{sh[6:0], i_io[0]};
	wire [3:0] next_bits = bits + {1'b0, lane_w};
	wire       shifting  = (state == sfbfe_pkg::ST_OPCODE) |
		(state == sfbfe_pkg::ST_ADDR) | (state == sfbfe_pkg::ST_DATA_IN);
	wire       byte_done = rise & shifting &
		(next_bits == sfbfe_pkg::BYTE_BITS);

	// opcode decode
	wire [7:0] op       = rx_shift;
	wire is_dual_out    = op == sfbfe_pkg::OP_READ_DUAL_OUT;
	wire is_dual_io     = op == sfbfe_pkg::OP_READ_DUAL_IO;
	wire is_quad_out    = op == sfbfe_pkg::OP_READ_QUAD_OUT;
	wire is_quad_io     = op == sfbfe_pkg::OP_READ_QUAD_IO;
	wire is_quad        = is_quad_out | is_quad_io;
	wire is_read        = is_dual_out | is_dual_io | is_quad;
	wire op_reject      = busy | (is_quad & ~qe);
	wire [2:0] op_addr_w = four_wire_instruction_mode ? sfbfe_pkg::LANE4 :
		is_dual_io ? sfbfe_pkg::LANE2 :
		is_quad_io ? sfbfe_pkg::LANE4 : sfbfe_pkg::LANE1;
	wire [2:0] op_addr_n = (is_dual_io | is_quad_io) ?
		sfbfe_pkg::ADDR_MODE : sfbfe_pkg::ADDR_BYTES;
	wire [3:0] op_dummy = (is_dual_out | is_quad_out) ?
		sfbfe_pkg::DUMMY_LONG :
		is_quad_io ? sfbfe_pkg::DUMMY_QIO : sfbfe_pkg::DUMMY_NONE;
	wire [2:0] op_out_w = (four_wire_instruction_mode | is_quad) ? sfbfe_pkg::LANE4 :
		sfbfe_pkg::LANE2;

	// output shifting; an empty buffer sends fill bytes, never stalls
	wire       tx_load  = txleft == 4'h0;
	wire [7:0] tx_cur   = tx_load ? (fifo_valid ? fifo_data :
		sfbfe_pkg::FILL_BYTE) : txsh;
	wire       tx_pop   = fall & (state == sfbfe_pkg::ST_DATA_OUT) &
		tx_load & fifo_valid;
	wire [7:0] tx_next  = (out_w == sfbfe_pkg::LANE4) ? {tx_cur[3:0], 4'h0} :
		(out_w == sfbfe_pkg::LANE2) ? {tx_cur[5:0], 2'b00} :
		{tx_cur[6:0], 1'b0};
	wire [3:0] tx_left  = (tx_load ? sfbfe_pkg::BYTE_BITS : txleft) -
		{1'b0, out_w};
	wire [3:0] tx_pins  = (out_w == sfbfe_pkg::LANE4) ? tx_cur[7:4] :
		(out_w == sfbfe_pkg::LANE2) ? {2'b00, tx_cur[7:6]} :
		{2'b00, tx_cur[7], 1'b0};
	wire [3:0] tx_oe_n  = (out_w == sfbfe_pkg::LANE4) ? sfbfe_pkg::OE_QUAD :
		(out_w == sfbfe_pkg::LANE2) ? sfbfe_pkg::OE_DUAL :
		sfbfe_pkg::OE_SINGLE;

	sfbfe_fifo #(
		.WIDTH(sfbfe_pkg::FIFO_WIDTH),
		.DEPTH(sfbfe_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_in_data  (i_tx_data),
		.i_in_valid (i_tx_valid),
		.o_in_ready (o_tx_ready),
		.o_out_data (fifo_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(tx_pop)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sclk_q  <= 1'b0;
			rst_cnt <= '0;
			o_abort <= 1'b0;
		end else begin
			sclk_q  <= i_sclk;
			o_abort <= dev_reset;
			if (!rst_low) begin
				rst_cnt <= '0;
			end else if (!dev_reset &&
				rst_cnt != sfbfe_pkg::CNT_W'(sfbfe_pkg::HW_RESET_CYCLES)) begin
				rst_cnt <= rst_cnt + 1'b1;
			end else if (dev_reset) begin
				rst_cnt <= rst_cnt + 1'b1;
			end
		end
	end

	// pause follows the pin only while the clock is low
	always_ff @(posedge i_clk) begin
		if (i_rst || !hold_ok) begin
			o_paused <= 1'b0;
		end else if (!i_sclk) begin
			o_paused <= ~i_io[3];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || dev_reset) begin
			o_four_wire_instruction_mode <= 1'b0;
			armed           <= 1'b0;
			busy_cnt        <= '0;
			o_sw_reset_busy <= 1'b0;
		end else begin
			if (busy) begin
				busy_cnt        <= busy_cnt - 1'b1;
				o_sw_reset_busy <= busy_cnt != sfbfe_pkg::CNT_W'(1);
			end
			if (byte_done && state == sfbfe_pkg::ST_OPCODE && !busy) begin
				armed <= op == sfbfe_pkg::OP_RESET_ENABLE;
				if (op == sfbfe_pkg::OP_ENTER_FOUR && qe) begin
					o_four_wire_instruction_mode <= 1'b1;
				end
				if (op == sfbfe_pkg::OP_EXIT_FOUR) begin
					o_four_wire_instruction_mode <= 1'b0;
				end
				if (op == sfbfe_pkg::OP_RESET && armed) begin
					o_four_wire_instruction_mode <= 1'b0;
					busy_cnt        <= sfbfe_pkg::CNT_W'(
						sfbfe_pkg::SW_RESET_CYCLES);
					o_sw_reset_busy <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || dev_reset) begin
			state  <= sfbfe_pkg::ST_OPCODE;
			lane_w <= sfbfe_pkg::LANE1;
		end else if (i_cs_n || rst_low) begin
			state  <= sfbfe_pkg::ST_OPCODE;
			lane_w <= four_wire_instruction_mode ? sfbfe_pkg::LANE4 : sfbfe_pkg::LANE1;
		end else if (byte_done) begin
			case (state)
				sfbfe_pkg::ST_OPCODE: begin
					if (op_reject) begin
						state <= sfbfe_pkg::ST_IGNORE;
					end else if (is_read) begin
						state  <= sfbfe_pkg::ST_ADDR;
						lane_w <= op_addr_w;
					end else if (op == sfbfe_pkg::OP_ENTER_FOUR ||
						op == sfbfe_pkg::OP_EXIT_FOUR ||
						op == sfbfe_pkg::OP_RESET_ENABLE ||
						op == sfbfe_pkg::OP_RESET) begin
						state <= sfbfe_pkg::ST_IGNORE;
					end else begin
						state <= sfbfe_pkg::ST_DATA_IN;
					end
				end
				sfbfe_pkg::ST_ADDR: begin
					if (left == 3'h1) begin
						state <= (dummy == sfbfe_pkg::DUMMY_NONE) ?
							sfbfe_pkg::ST_DATA_OUT : sfbfe_pkg::ST_DUMMY;
					end
				end
				default: begin
					state <= state;
				end
			endcase
		end else if (rise && state == sfbfe_pkg::ST_DUMMY && dummy == 4'h1) begin
			state <= sfbfe_pkg::ST_DATA_OUT;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bits        <= '0;
			sh          <= '0;
			left        <= '0;
			dummy       <= '0;
			out_w       <= sfbfe_pkg::LANE1;
			o_opcode    <= '0;
			o_cmd_valid <= 1'b0;
			o_rx_byte   <= '0;
			o_rx_valid  <= 1'b0;
		end else begin
			o_cmd_valid <= 1'b0;
			o_rx_valid  <= 1'b0;
			if (i_cs_n || rst_low) begin
				bits  <= '0;
				out_w <= sfbfe_pkg::LANE1;
			end else if (rise && shifting) begin
				sh   <= rx_shift;
				bits <= byte_done ? 4'h0 : next_bits;
			end else if (rise && state == sfbfe_pkg::ST_DUMMY) begin
				dummy <= dummy - 1'b1;
			end
			if (byte_done && state == sfbfe_pkg::ST_OPCODE) begin
				o_opcode    <= op;
				o_cmd_valid <= ~op_reject;
				left        <= op_addr_n;
				dummy       <= op_dummy;
				out_w       <= op_out_w;
			end else if (byte_done) begin
				o_rx_byte  <= rx_shift;
				o_rx_valid <= 1'b1;
				left       <= left - 1'b1;
			end
		end
	end

	// data lines change only on the falling clock edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			txsh      <= '0;
			txleft    <= '0;
			o_io_out  <= sfbfe_pkg::IO_IDLE;
			o_io_oe_n <= sfbfe_pkg::OE_FLOAT;
		end else begin
			if (state != sfbfe_pkg::ST_DATA_OUT) begin
				txleft <= '0;
			end else if (fall) begin
				txsh     <= tx_next;
				txleft   <= tx_left;
				o_io_out <= tx_pins;
			end
			if (float_out) begin
				o_io_oe_n <= sfbfe_pkg::OE_FLOAT;
			end else if (fall) begin
				o_io_oe_n <= tx_oe_n;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	out_on_fall_a: assert property ($changed(o_io_out) |-> $past(fall))
		else $error("data lines changed outside a falling clock edge");
	deselect_float_a: assert property (i_cs_n |=> o_io_oe_n == 4'hf)
		else $error("outputs driven while deselected");
	pause_float_a: assert property (o_paused |=> o_io_oe_n == 4'hf)
		else $error("outputs driven during pause");
	quad_no_pause_a: assert property ((qe || four_wire_instruction_mode) |=> !o_paused)
		else $error("pause active in quad operation");
	enter_needs_qe_a: assert property ($rose(four_wire_instruction_mode) |-> $past(qe))
		else $error("four-wire mode entered without quad enable");
	opcode_lanes_a: assert property (
		(state == sfbfe_pkg::ST_OPCODE && !i_cs_n) |->
		lane_w == (four_wire_instruction_mode ? 3'h4 : 3'h1))
		else $error("opcode lane width wrong for mode");
	sw_reset_seq_a: assert property ($rose(busy) |->
		$past(armed) && !four_wire_instruction_mode ##1 busy [*8])
		else $error("software reset without enable or too short");
	busy_reject_a: assert property (busy |=> !o_cmd_valid)
		else $error("command accepted during software reset");
	hw_reset_a: assert property (o_abort |->
		$past(rst_low) && !four_wire_instruction_mode && !busy)
		else $error("hardware reset did not return to power-on state");
	rst_pin_block_a: assert property (!i_rst_pin_n |=>
		!o_cmd_valid && o_io_oe_n == 4'hf)
		else $error("commands or outputs active with reset pin low");

	four_wire_cover: cover property ($rose(four_wire_instruction_mode));
	quad_read_cover: cover property (o_cmd_valid && o_opcode == 8'heb);
	pause_cover: cover property ($fell(o_paused));
	sw_reset_cover: cover property ($fell(busy));
	hw_reset_cover: cover property (o_abort);
endmodule // sfbfe_top

// ---- dv/sfbfe_master.sv ----
`timescale 1ns/1ps

module sfbfe_master (
	input  wire logic       i_clk,
	// serial bus pins
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic      [3:0] o_io,
	input  wire logic [3:0] i_io
);
	logic       cpol;
	logic       hold_n;
	logic [3:0] relm;

	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_io   = 4'hf;
		cpol   = 1'b0;
		hold_n = 1'b1;
		relm   = 4'h0;
	end

	// released lines toggle so no stale level can pass for device data
	always @(posedge i_clk) begin
		if (|relm)
			o_io <= o_io ^ relm;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic start();
		@(posedge i_clk);
		o_sclk <= cpol;
		tick(3);
		o_cs_n <= 1'b0;
		tick(3);
		if (cpol) begin
			o_sclk <= 1'b0;
			tick(3);
		end
	endtask

	// select stays low across any pause; raising it would drop state
	// in mode 3 the clock only returns high once deselected: no extra rise
	task automatic stop();
		tick(3);
		o_cs_n <= 1'b1;
		relm   <= 4'h0;
		tick(3);
		o_sclk <= cpol;
		tick(6);
	endtask

	task automatic pause_pin(input logic v);
		@(posedge i_clk);
		hold_n <= v;
		o_io   <= {v, o_io[2:0]};
	endtask

	// n groups of w bits, msb first; r releases the lines to the device
	task automatic xfer(input int w, input int n, input logic [7:0] tx,
		input logic r, output logic [7:0] rx);
		logic [7:0] s;
		int         i;
		s  = tx;
		rx = 8'h00;
		for (i = 0; i < n; i++) begin
			@(posedge i_clk);
			relm <= !r ? 4'h0 : (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h2;
			if (!r)
				o_io <= (w == 4) ? s[7:4] : (w == 2) ?
					{hold_n, 1'b1, s[7:6]} : {hold_n, 2'b11, s[7]};
			s = s << w;
			tick(3);
			o_sclk <= 1'b1;
			rx = (w == 4) ? {rx[3:0], i_io} : (w == 2) ?
				{rx[5:0], i_io[1:0]} : {rx[6:0], i_io[1]};
			tick(3);
			o_sclk <= 1'b0;
		end
	endtask
endmodule // sfbfe_master

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
	logic       i_clk;
	logic       i_rst;
	logic       rst_pin_n;
	logic       qe;
	logic       sel;
	logic [7:0] tx_data;
	logic       tx_valid;
	logic       cs_n;
	logic       sclk;
	logic [3:0] m_io;
	logic [3:0] io_out;
	logic [3:0] oe_n;
	logic [3:0] io_wire;
	logic [7:0] opcode;
	logic       cmd_valid;
	logic       rx_valid;
	logic       tx_ready;
	logic       mode4;
	logic       paused;
	logic       busy;
	logic       abort;
	logic [7:0] rx;
	logic [7:0] rx_byte;
	int         n_mismatch;
	int         checks;
	int         n_cmd;
	int         n_rx;
	int         n_abort;
	int         c;
	int         t;

	assign io_wire = (oe_n & m_io) | (~oe_n & io_out);

	sfbfe_master m (
		.i_clk  (i_clk),
		.o_cs_n (cs_n),
		.o_sclk (sclk),
		.o_io   (m_io),
		.i_io   (io_wire)
	);

	sfbfe_top uut (
		.i_clk                        (i_clk),
		.i_rst                        (i_rst),
		.i_cs_n                       (cs_n),
		.i_sclk                       (sclk),
		.i_io                         (io_wire),
		.o_io_out                     (io_out),
		.o_io_oe_n                    (oe_n),
		.i_rst_pin_n                  (rst_pin_n),
		.i_quad_enable_bit            (qe),
		.i_pause_or_reset_pin_select  (sel),
		.o_opcode                     (opcode),
		.o_cmd_valid                  (cmd_valid),
		.o_rx_byte                    (rx_byte),
		.o_rx_valid                   (rx_valid),
		.i_tx_data                    (tx_data),
		.i_tx_valid                   (tx_valid),
		.o_tx_ready                   (tx_ready),
		.o_four_wire_instruction_mode (mode4),
		.o_paused                     (paused),
		.o_sw_reset_busy              (busy),
		.o_abort                      (abort)
	);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (cmd_valid === 1'b1)
			n_cmd++;
		if (rx_valid === 1'b1)
			n_rx++;
		if (abort === 1'b1)
			n_abort++;
	end

	task automatic chk(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cmd(input int w, input logic [7:0] op);
		m.start();
		m.xfer(w, 8 / w, op, 1'b0, rx);
		m.stop();
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge i_clk);
		n_mismatch++;
		conclude();
	end

	initial begin
		i_rst = 1'b1;
		rst_pin_n = 1'b1;
		qe = 1'b0;
		sel = 1'b0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		n_mismatch = 0;
		checks = 0;
		n_cmd = 0;
		n_rx = 0;
		n_abort = 0;
		m.tick(20);
		i_rst <= 1'b0;
		m.tick(2);
		chk("oe_n", oe_n, 4'hf);
		chk("mode", mode4, 1'b0);
		chk("paused", paused, 1'b0);
		chk("busy", busy, 1'b0);
		chk("tx_ready", tx_ready, 1'b1);
		$display("test reset done");

		// 17 offers: the last one must be refused by the full buffer
		for (t = 0; t < 17; t++) begin
			@(posedge i_clk);
			tx_valid <= 1'b1;
			tx_data  <= 8'ha0 + 8'(t);
		end
		@(posedge i_clk);
		tx_valid <= 1'b0;
		m.tick(1);
		chk("tx_ready_full", tx_ready, 1'b0);
		m.start();
		m.xfer(1, 4, 8'h90, 1'b0, rx);
		m.stop();
		c = n_cmd;
		m.start();
		m.xfer(1, 8, 8'h3b, 1'b0, rx);
		for (t = 0; t < 4; t++)
			m.xfer(1, 8, 8'h11 + 8'(t), 1'b0, rx);
		chk("n_cmd", 8'(n_cmd - c), 8'h01);
		chk("opcode", opcode, 8'h3b);
		chk("n_rx", 8'(n_rx), 8'h03);
		chk("rx_byte", rx_byte, 8'h13);
		for (t = 0; t < 17; t++) begin
			m.xfer(2, 4, 8'h00, 1'b1, rx);
			chk("dual_data", rx, t < 16 ? 8'ha0 + 8'(t) : 8'hff);
		end
		chk("oe_dual", oe_n, 4'hc);
		m.stop();
		chk("oe_float", oe_n, 4'hf);
		chk("tx_ready_empty", tx_ready, 1'b1);
		$display("test dual read done");

		c = n_cmd;
		m.start();
		m.xfer(1, 4, 8'h66, 1'b0, rx);
		m.pause_pin(1'b0);
		m.tick(4);
		chk("paused", paused, 1'b1);
		m.xfer(1, 4, 8'hff, 1'b0, rx);
		chk("oe_paused", oe_n, 4'hf);
		m.pause_pin(1'b1);
		m.tick(4);
		chk("resumed", paused, 1'b0);
		m.xfer(1, 4, 8'h60, 1'b0, rx);
		m.stop();
		chk("pause_op", opcode, 8'h66);
		chk("pause_cmd", 8'(n_cmd - c), 8'h01);
		$display("test pause done");

		qe <= 1'b1;
		cmd(1, 8'h38);
		chk("enter", mode4, 1'b1);
		cmd(4, 8'h66);
		cmd(4, 8'h99);
		chk("sw_busy", busy, 1'b1);
		chk("sw_mode", mode4, 1'b0);
		c = n_cmd;
		cmd(1, 8'h6b);
		chk("busy_reject", 8'(n_cmd - c), 8'h00);
		for (t = 0; t < 2000 && busy !== 1'b0; t++)
			@(posedge i_clk);
		chk("busy_end", busy, 1'b0);
		chk("busy_span", t > 800, 1'b1);
		m.cpol = 1'b1;
		cmd(1, 8'h66);
		chk("mode3_op", opcode, 8'h66);
		m.cpol = 1'b0;
		cmd(1, 8'h38);
		cmd(4, 8'h99);
		chk("disarmed", busy, 1'b0);
		chk("four_wire", mode4, 1'b1);
		cmd(4, 8'hff);
		chk("exit", mode4, 1'b0);
		qe <= 1'b0;
		c = n_cmd;
		cmd(1, 8'h38);
		chk("no_enter", mode4, 1'b0);
		cmd(1, 8'h6b);
		chk("quad_refused", 8'(n_cmd - c), 8'h01);
		qe <= 1'b1;
		cmd(1, 8'h6b);
		chk("quad_taken", 8'(n_cmd - c), 8'h02);
		@(posedge i_clk);
		tx_valid <= 1'b1;
		tx_data  <= 8'h5a;
		@(posedge i_clk);
		tx_valid <= 1'b0;
		m.start();
		m.xfer(1, 8, 8'heb, 1'b0, rx);
		for (t = 0; t < 5; t++)
			m.xfer(4, t < 4 ? 2 : 4, 8'h00, 1'b0, rx);
		m.xfer(4, 2, 8'h00, 1'b1, rx);
		chk("quad_data", rx, 8'h5a);
		chk("oe_quad", oe_n, 4'h0);
		m.xfer(4, 2, 8'h00, 1'b1, rx);
		chk("quad_fill", rx, 8'hff);
		m.stop();
		$display("test modes and soft reset done");

		cmd(1, 8'h38);
		sel <= 1'b1;
		c = n_cmd;
		t = n_abort;
		rst_pin_n <= 1'b0;
		cmd(4, 8'h66);
		chk("hw_block", 8'(n_cmd - c), 8'h00);
		m.tick(100);
		chk("hw_abort", 8'(n_abort - t), 8'h01);
		chk("hw_mode", mode4, 1'b0);
		rst_pin_n <= 1'b1;
		m.tick(2);
		rst_pin_n <= 1'b0;
		m.tick(50);
		rst_pin_n <= 1'b1;
		m.tick(2);
		chk("hw_short", 8'(n_abort - t), 8'h01);
		m.start();
		m.pause_pin(1'b0);
		m.tick(110);
		chk("io3_data", 8'(n_abort - t), 8'h01);
		qe <= 1'b0;
		m.tick(110);
		chk("shared_rst", 8'(n_abort - t), 8'h02);
		chk("no_pause", paused, 1'b0);
		m.pause_pin(1'b1);
		m.stop();
		$display("test hardware reset done");
		conclude();
	end
endmodule // testbench
